// ### shl_health_led.sv
// front panel health indicator logic with apb control and status
`include "shl_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module shl_health_led
    import shl_pkg::*;
#(
    parameter int NUM_EXT = 4,          // externally serviceable units
    parameter int NUM_INT = 8,          // internally serviceable units
    parameter int HALF_2HZ_CYCLES = `SHL_HALF_2HZ_MS * `SHL_CLK_KHZ  // fast flash half period
) (
    input wire logic ref_clk_in,                   // system clock, 125 MHz
    input wire logic rst_n_in,                     // ac or standby power cycle, low
    input wire logic sys_power_in,                 // main power is on
    input wire logic hard_reset_in,                // operator hard reset pulse
    input wire logic [NUM_EXT-1:0] ext_fail_in,    // external unit failure report
    input wire logic [NUM_EXT-1:0] ext_good_in,    // external unit good report
    input wire logic [NUM_INT-1:0] int_fail_in,    // internal unit failure report
    input wire logic [NUM_INT-1:0] int_good_in,    // internal unit good report
    input wire logic psel,                         // apb select
    input wire logic penable,                      // apb access phase
    input wire logic pwrite,                       // apb write
    input wire logic [11:0] paddr,                 // apb byte address
    input wire logic [31:0] pwdata,                // apb write data
    output logic [31:0] prdata,                    // apb read data
    output logic pready,                           // apb ready
    output logic pslverr,                          // apb error
    output logic power_led_out,                    // power indicator green
    output logic ext_green_out,                    // external health green
    output logic ext_amber_out,                    // external health amber
    output logic int_green_out,                    // internal health green
    output logic int_amber_out,                    // internal health amber
    output logic sys_green_out,                    // system health green
    output logic sys_amber_out,                    // system health amber
    output logic sys_red_out,                      // system health red
    output logic [NUM_EXT-1:0] ext_comp_led_out,   // failed external unit leds
    output logic [NUM_INT-1:0] int_comp_led_out    // diagnostic panel leds
);

    // refuse sizes the latch storage cannot hold
    initial begin
        if (NUM_EXT < 1 || NUM_EXT > `SHL_MAX_UNITS)
            $error("NUM_EXT out of range");
        if (NUM_INT < 1 || NUM_INT > `SHL_MAX_UNITS)
            $error("NUM_INT out of range");
        if (HALF_2HZ_CYCLES < 2)
            $error("HALF_2HZ_CYCLES too small");
    end

    localparam logic [31:0] HALF_LAST = 32'(HALF_2HZ_CYCLES - 1);  // divider wrap

    // timebase notes:
    // one free running divider feeds every flashing output
    // fast phase toggles each HALF_2HZ_CYCLES clocks
    // slow phase toggles when the fast phase falls
    // so the slow edges always sit on fast edges
    // all ambers share the slow phase, never drifting apart
    // red uses the fast phase for the fatal indication
    // both phases start low after the power cycle
    // a flashing output starts in the current divider phase, lit or dark
    // divider never stops, so flashing needs no start event
    // hazard: a very small half period makes the leds look steady
    // that is why the elaboration check wants at least two clocks

    shl_state_type state_ff;   // registered state
    shl_state_type nxt_state;  // next state

    // per-unit latch next values
    logic [`SHL_MAX_UNITS-1:0] nxt_ext_fault;  // external latches
    logic [`SHL_MAX_UNITS-1:0] nxt_int_fault;  // internal latches

    // apb decode terms
    logic apb_access;   // access phase, first cycle
    logic apb_commit;   // access phase, completing edge
    logic wr_ctrl;      // control write completes
    logic wr_event;     // event write completes
    logic addr_hit;     // address is mapped
    logic ext_any;      // some external unit failed
    logic int_any;      // some internal unit failed
    logic power_rise;   // main power just came on
    logic [31:0] rd_word; // read mux

    // one fault latch per unit; a failure report beats a good report
    genvar gi;
    generate
        for (gi = 0; gi < `SHL_MAX_UNITS; gi++) begin : g_unit
            if (gi < NUM_EXT) begin : g_ext
                assign nxt_ext_fault[gi] = ext_fail_in[gi] |
                    (state_ff.ext_fault[gi] & ~ext_good_in[gi]);
            end else begin : g_ext_none
                assign nxt_ext_fault[gi] = 1'b0;  // unused slot
            end
            if (gi < NUM_INT) begin : g_int
                assign nxt_int_fault[gi] = int_fail_in[gi] |
                    (state_ff.int_fault[gi] & ~int_good_in[gi]);
            end else begin : g_int_none
                assign nxt_int_fault[gi] = 1'b0;  // unused slot
            end
        end
    endgenerate

    // apb phase and address decode
    always_comb begin
        apb_access = psel & penable & ~state_ff.pready;
        apb_commit = psel & penable & state_ff.pready;
        addr_hit = (paddr == `SHL_OFF_CTRL) || (paddr == `SHL_OFF_EVENT) ||
            (paddr == `SHL_OFF_FAULTS) || (paddr == `SHL_OFF_LEDS);
        wr_ctrl = apb_commit & pwrite & (paddr == `SHL_OFF_CTRL);
        wr_event = apb_commit & pwrite & (paddr == `SHL_OFF_EVENT);
        ext_any = |state_ff.ext_fault;
        int_any = |state_ff.int_fault;
        power_rise = sys_power_in & ~state_ff.power_prev;
    end

    // read data for the addressed register
    always_comb begin
        rd_word = `SHL_RESET_WORD;
        case (paddr)
            `SHL_OFF_CTRL: begin
                rd_word[`SHL_CTRL_MC_READY] = state_ff.mc_ready;
                rd_word[`SHL_CTRL_BOOT_BEGUN] = state_ff.boot_begun;
                rd_word[`SHL_CTRL_OS_BOOT] = state_ff.os_booting;
            end
            `SHL_OFF_EVENT: begin
                rd_word[`SHL_EVT_WARN] = state_ff.sys_warn;
                rd_word[`SHL_EVT_FATAL] = state_ff.sys_fatal;
            end
            `SHL_OFF_FAULTS: begin
                rd_word[`SHL_FLT_EXT_LSB +: `SHL_MAX_UNITS] = state_ff.ext_fault;
                rd_word[`SHL_FLT_INT_LSB +: `SHL_MAX_UNITS] = state_ff.int_fault;
            end
            `SHL_OFF_LEDS: begin
                rd_word[`SHL_LED_EXT_LSB +: 2] = state_ff.ext_vfp;
                rd_word[`SHL_LED_INT_LSB +: 2] = state_ff.int_vfp;
                rd_word[`SHL_LED_SYS_LSB +: 2] = state_ff.sys_vfp;
                rd_word[`SHL_LED_PWR_BIT] = state_ff.power_led;
            end
            default: begin
                rd_word = `SHL_RESET_WORD;  // unmapped reads zero
            end
        endcase
    end

    // indicator notes:
    // power led follows main power with no software involved
    // external and internal leds each own a bank of unit latches
    // a latch is set by a failure pulse, cleared by a good pulse
    // a failure and a good pulse together leave the latch set
    // only the ac or standby power cycle clears all latches at once
    // external latches never reach the internal indicator
    // internal latches never reach the external indicator
    // component leds are plain copies of the latches
    // so an external or internal amber led always has a lit unit led beside it
    // and an external or internal green led never has one lit
    // boot flags survive standby so internal green is kept there
    // a fresh rise of main power restarts the boot flags
    // system led ranks fatal red over warning amber over green
    // logged warning and fatal states stay until explicitly cleared

    // next-state logic for the whole block
    always_comb begin
        nxt_state = state_ff;

        // shared timebase: 1 Hz toggles on every second 2 Hz toggle
        if (state_ff.flash_cnt == HALF_LAST) begin
            nxt_state.flash_cnt = `SHL_RESET_WORD;
            nxt_state.flash_2hz = ~state_ff.flash_2hz;
            if (state_ff.flash_2hz) begin
                nxt_state.flash_1hz = ~state_ff.flash_1hz;
            end
        end else begin
            nxt_state.flash_cnt = state_ff.flash_cnt + 32'h0000_0001;
        end

        // fault latches, only cleared by good reports or reset
        nxt_state.ext_fault = nxt_ext_fault;
        nxt_state.int_fault = nxt_int_fault;
        nxt_state.power_prev = sys_power_in;

        // software control bits
        if (wr_ctrl) begin
            nxt_state.mc_ready = pwdata[`SHL_CTRL_MC_READY];
            nxt_state.boot_begun = pwdata[`SHL_CTRL_BOOT_BEGUN];
            nxt_state.os_booting = pwdata[`SHL_CTRL_OS_BOOT];
        end
        // new power-up restarts the boot sequence; standby keeps it
        if (power_rise) begin
            nxt_state.boot_begun = 1'b0;
            nxt_state.os_booting = 1'b0;
        end

        // logged system events; a new log beats its clear
        if (wr_event && pwdata[`SHL_EVT_LOGS_SEEN]) begin
            nxt_state.sys_warn = 1'b0;
        end
        if (wr_event && pwdata[`SHL_EVT_WARN]) begin
            nxt_state.sys_warn = 1'b1;
        end
        if (hard_reset_in) begin
            nxt_state.sys_fatal = 1'b0;
        end
        if (wr_event && pwdata[`SHL_EVT_FATAL]) begin
            nxt_state.sys_fatal = 1'b1;
        end

        // power indicator follows main power alone
        nxt_state.power_led = sys_power_in;

        // external indicator, amber over green
        nxt_state.ext_comp = state_ff.ext_fault;
        if (ext_any) begin
            nxt_state.ext_green = 1'b0;
            nxt_state.ext_amber = state_ff.flash_1hz;
            nxt_state.ext_vfp = SHL_VFP_FAILED;
        end else if (sys_power_in && state_ff.mc_ready) begin
            nxt_state.ext_green = 1'b1;
            nxt_state.ext_amber = 1'b0;
            nxt_state.ext_vfp = SHL_VFP_OK;
        end else begin
            nxt_state.ext_green = 1'b0;
            nxt_state.ext_amber = 1'b0;
            nxt_state.ext_vfp = SHL_VFP_NONE;
        end

        // internal indicator: amber only while a panel led is lit
        nxt_state.int_comp = state_ff.int_fault;
        if (int_any) begin
            nxt_state.int_green = 1'b0;
            nxt_state.int_amber = state_ff.flash_1hz;
            nxt_state.int_vfp = SHL_VFP_FAILED;
        end else if (state_ff.boot_begun) begin
            nxt_state.int_green = 1'b1;
            nxt_state.int_amber = 1'b0;
            nxt_state.int_vfp = SHL_VFP_OK;
        end else begin
            nxt_state.int_green = 1'b0;
            nxt_state.int_amber = 1'b0;
            nxt_state.int_vfp = SHL_VFP_NONE;
        end

        // system indicator: fatal red over warning amber over green
        if (state_ff.sys_fatal) begin
            nxt_state.sys_green = 1'b0;
            nxt_state.sys_amber = 1'b0;
            nxt_state.sys_red = state_ff.flash_2hz;
            nxt_state.sys_vfp = SHL_VFP_FATAL;
        end else if (state_ff.sys_warn) begin
            nxt_state.sys_green = 1'b0;
            nxt_state.sys_amber = state_ff.flash_1hz;
            nxt_state.sys_red = 1'b0;
            nxt_state.sys_vfp = SHL_VFP_FAILED;
        end else if (sys_power_in && state_ff.os_booting) begin
            nxt_state.sys_green = 1'b1;
            nxt_state.sys_amber = 1'b0;
            nxt_state.sys_red = 1'b0;
            nxt_state.sys_vfp = SHL_VFP_OK;
        end else begin
            nxt_state.sys_green = 1'b0;
            nxt_state.sys_amber = 1'b0;
            nxt_state.sys_red = 1'b0;
            nxt_state.sys_vfp = SHL_VFP_NONE;
        end

        // apb slave: one wait cycle, then ready for one cycle
        nxt_state.pready = apb_access;
        if (apb_access) begin
            nxt_state.pslverr = ~addr_hit;
            nxt_state.prdata = (pwrite || !addr_hit) ? `SHL_RESET_WORD : rd_word;
        end else begin
            nxt_state.pslverr = 1'b0;
            nxt_state.prdata = `SHL_RESET_WORD;
        end
    end

    // apb notes:
    // one wait state: ready comes the cycle after access starts
    // writes take effect only on the edge with ready high
    // unmapped addresses answer with an error and zero data
    // write answers carry zero data as well
    // a master may start its next setup right after completion
    // read data is captured from the state of the access cycle

    // state register; reset is the ac or standby power cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= '0;  // all latches, flags and leds clear
        end else begin
            state_ff <= nxt_state;
        end
    end

    // output notes:
    // every port below is a copy of a state bit
    // no gate stands between a flip-flop and a pin
    // unused latch slots above the unit counts stay zero
    // only the low unit slots are brought out to the pins

    // outputs straight from the state register
    always_comb begin
        prdata = state_ff.prdata;
        pready = state_ff.pready;
        pslverr = state_ff.pslverr;
        power_led_out = state_ff.power_led;
        ext_green_out = state_ff.ext_green;
        ext_amber_out = state_ff.ext_amber;
        int_green_out = state_ff.int_green;
        int_amber_out = state_ff.int_amber;
        sys_green_out = state_ff.sys_green;
        sys_amber_out = state_ff.sys_amber;
        sys_red_out = state_ff.sys_red;
        ext_comp_led_out = state_ff.ext_comp[NUM_EXT-1:0];
        int_comp_led_out = state_ff.int_comp[NUM_INT-1:0];
    end

endmodule

`default_nettype wire

// ### shl_health_props.sv
// concurrent checks on the health indicator block ports
`timescale 1ns/1ns
`default_nettype none
module shl_health_props #(
    parameter int NUM_EXT = 4,          // external units
    parameter int NUM_INT = 8,          // internal units
    parameter int HALF_2HZ_CYCLES = 4   // fast flash half period
) (
    input wire logic ref_clk_in,                 // clock
    input wire logic rst_n_in,                   // reset, low
    input wire logic sys_power_in,               // main power
    input wire logic [NUM_EXT-1:0] ext_fail_in,  // ext failure
    input wire logic [NUM_INT-1:0] int_fail_in,  // int failure
    input wire logic psel,                       // apb select
    input wire logic penable,                    // apb enable
    input wire logic pready,                     // apb ready
    input wire logic power_led_out,              // power led
    input wire logic ext_green_out,              // ext green
    input wire logic ext_amber_out,              // ext amber
    input wire logic int_green_out,              // int green
    input wire logic int_amber_out,              // int amber
    input wire logic sys_red_out,                // sys red
    input wire logic [NUM_EXT-1:0] ext_comp_led_out, // ext unit leds
    input wire logic [NUM_INT-1:0] int_comp_led_out  // panel leds
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_power_follow: assert property ($rose(sys_power_in) |=> power_led_out)
        else $error("power led did not follow power");
    a_apb_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_ext_amber_lit: assert property (ext_amber_out |-> |ext_comp_led_out && !ext_green_out)
        else $error("ext amber without unit led or with green");
    a_int_amber_lit: assert property (int_amber_out |-> |int_comp_led_out && !int_green_out)
        else $error("int amber without panel led or with green");
    a_int_green_clean: assert property (int_green_out |-> int_comp_led_out == '0)
        else $error("int green while panel led lit");
    a_ext_not_int: assert property ($rose(|int_comp_led_out) |-> $past(|int_fail_in, 2))
        else $error("panel led lit without internal failure");
    a_int_not_ext: assert property ($rose(|ext_comp_led_out) |-> $past(|ext_fail_in, 2))
        else $error("ext unit led lit without external failure");
    a_fail_latch: assert property (|ext_fail_in |-> ##2 |ext_comp_led_out)
        else $error("failure report not latched");
    a_flash_phase: assert property (|ext_comp_led_out && |int_comp_led_out |->
        ext_amber_out == int_amber_out)
        else $error("amber indicators out of phase");
    a_slow_flash: assert property ($rose(ext_amber_out) && $past(|ext_comp_led_out) |->
        (ext_amber_out || ext_comp_led_out == '0) [*8] ##1 !ext_amber_out)
        else $error("ext amber half period wrong");
    a_fast_flash: assert property ($rose(sys_red_out) |-> ##4 !sys_red_out)
        else $error("red half period wrong");
    c_ext_amber: cover property ($rose(ext_amber_out));
    c_int_amber: cover property ($rose(int_amber_out));
    c_red: cover property ($rose(sys_red_out));
endmodule
bind shl_health_led shl_health_props #(.NUM_EXT(NUM_EXT), .NUM_INT(NUM_INT),
    .HALF_2HZ_CYCLES(HALF_2HZ_CYCLES)) props_u (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .sys_power_in(sys_power_in), .ext_fail_in(ext_fail_in),
    .int_fail_in(int_fail_in), .psel(psel), .penable(penable), .pready(pready),
    .power_led_out(power_led_out), .ext_green_out(ext_green_out),
    .ext_amber_out(ext_amber_out), .int_green_out(int_green_out),
    .int_amber_out(int_amber_out), .sys_red_out(sys_red_out),
    .ext_comp_led_out(ext_comp_led_out), .int_comp_led_out(int_comp_led_out));
`default_nettype wire

// ### shl_pkg.sv
// types shared by the server health indicator logic
`include "shl_regs.svh"

package shl_pkg;

    // text state shown on the virtual_front_panel
    typedef enum logic [1:0] {
        SHL_VFP_NONE,
        SHL_VFP_OK,
        SHL_VFP_FAILED,
        SHL_VFP_FATAL
    } shl_vfp_type;

    // whole state of the indicator block
    typedef struct packed {
        logic [31:0] flash_cnt;                    // timebase divider
        logic flash_2hz;                           // fast flash phase
        logic flash_1hz;                           // slow flash phase
        logic [`SHL_MAX_UNITS-1:0] ext_fault;      // external unit latches
        logic [`SHL_MAX_UNITS-1:0] int_fault;      // internal unit latches
        logic mc_ready;                            // controller can drive leds
        logic boot_begun;                          // boot-begun event seen
        logic os_booting;                          // os boot has begun
        logic sys_warn;                            // logged warning
        logic sys_fatal;                           // logged fatal fault
        logic power_prev;                          // power seen last cycle
        logic power_led;                           // power indicator
        logic ext_green;                           // external green
        logic ext_amber;                           // external amber
        logic int_green;                           // internal green
        logic int_amber;                           // internal amber
        logic sys_green;                           // system green
        logic sys_amber;                           // system amber
        logic sys_red;                             // system red
        logic [`SHL_MAX_UNITS-1:0] ext_comp;       // external unit leds
        logic [`SHL_MAX_UNITS-1:0] int_comp;       // diagnostic panel leds
        shl_vfp_type ext_vfp;                      // external text state
        shl_vfp_type int_vfp;                      // internal text state
        shl_vfp_type sys_vfp;                      // system text state
        logic pready;                              // apb ready
        logic pslverr;                             // apb error
        logic [31:0] prdata;                       // apb read data
    } shl_state_type;

endpackage

// ### shl_regs.svh
// register offsets, field positions, reset values and timing for the health indicators
`ifndef SHL_REGS_SVH
`define SHL_REGS_SVH

// byte offsets of the apb registers
`define SHL_OFF_CTRL 12'h000
`define SHL_OFF_EVENT 12'h004
`define SHL_OFF_FAULTS 12'h008
`define SHL_OFF_LEDS 12'h00C

// control register bits
`define SHL_CTRL_MC_READY 0
`define SHL_CTRL_BOOT_BEGUN 1
`define SHL_CTRL_OS_BOOT 2

// event register bits, write one to fire
`define SHL_EVT_WARN 0
`define SHL_EVT_FATAL 1
`define SHL_EVT_LOGS_SEEN 2

// fault latch register layout
`define SHL_FLT_EXT_LSB 0
`define SHL_FLT_INT_LSB 16

// indicator state register layout
`define SHL_LED_EXT_LSB 0
`define SHL_LED_INT_LSB 2
`define SHL_LED_SYS_LSB 4
`define SHL_LED_PWR_BIT 8

// unit count limit and reset values
`define SHL_MAX_UNITS 16
`define SHL_RESET_WORD 32'h0000_0000
`define SHL_RESET_UNITS 16'h0000

// timebase: clock rate and half period of the fast flash
`define SHL_CLK_KHZ 125000
`define SHL_HALF_2HZ_MS 250

`endif

// ### shl_unit_model.sv
// model of the unit fault reporters behind the management controller
`timescale 1ns/1ns
`default_nettype none
module shl_unit_model #(
    parameter int NUM_EXT = 4,  // external units
    parameter int NUM_INT = 8   // internal units
) (
    input wire logic ref_clk_in,                 // clock
    output var logic [NUM_EXT-1:0] ext_fail_out, // ext failure pulses
    output var logic [NUM_EXT-1:0] ext_good_out, // ext good pulses
    output var logic [NUM_INT-1:0] int_fail_out, // int failure pulses
    output var logic [NUM_INT-1:0] int_good_out  // int good pulses
);
    // reports idle low from time zero
    initial begin
        ext_fail_out = '0;
        ext_good_out = '0;
        int_fail_out = '0;
        int_good_out = '0;
    end
    // one-cycle report pulse, then back to idle
    task automatic report(input logic [NUM_EXT-1:0] ef, input logic [NUM_EXT-1:0] eg,
        input logic [NUM_INT-1:0] fi, input logic [NUM_INT-1:0] gi);
        @(posedge ref_clk_in);
        ext_fail_out <= ef;
        ext_good_out <= eg;
        int_fail_out <= fi;
        int_good_out <= gi;
        @(posedge ref_clk_in);
        ext_fail_out <= '0;
        ext_good_out <= '0;
        int_fail_out <= '0;
        int_good_out <= '0;
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the health indicator block
`include "shl_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk_in = 0, rst_n_in = 0, sys_power_in = 0, hard_reset_in = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, pwr, eg, ea, ig, ia, sg, sa, sr;
    logic [3:0] ef, eo, ec, hi, lo;
    logic [7:0] fi, gi, ic;
    int n_fail = 0, num_checks = 0;
    wire logic [3:0] grn = {pwr, eg, ig, sg};  // green group
    wire logic [3:0] amb = {ea, ia, sa, sr};   // flashing group
    always #4 ref_clk_in = ~ref_clk_in;
    shl_health_led #(.NUM_EXT(4), .NUM_INT(8), .HALF_2HZ_CYCLES(4)) dut_u (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sys_power_in(sys_power_in),
        .hard_reset_in(hard_reset_in), .ext_fail_in(ef), .ext_good_in(eo),
        .int_fail_in(fi), .int_good_in(gi), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_led_out(pwr), .ext_green_out(eg),
        .ext_amber_out(ea), .int_green_out(ig), .int_amber_out(ia),
        .sys_green_out(sg), .sys_amber_out(sa), .sys_red_out(sr),
        .ext_comp_led_out(ec), .int_comp_led_out(ic));
    shl_unit_model #(.NUM_EXT(4), .NUM_INT(8)) unit_u (.ref_clk_in(ref_clk_in),
        .ext_fail_out(ef), .ext_good_out(eo), .int_fail_out(fi), .int_good_out(gi));
    // value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk_in);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk_in);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (k == 20) chk(32'h0000_0bad, 32'h0000_0000);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // note which flashing outputs were seen high and low
    task automatic watch(input int n);
        hi = '0;
        lo = '0;
        repeat (n) begin
            @(posedge ref_clk_in);
            hi |= amb;
            lo |= ~amb;
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(4);
        rst_n_in <= 1;
        cyc(1);
        chk({28'h0, grn}, 32'h0000_0000);
        apb(0, `SHL_OFF_LEDS, 0); chk(rd, 32'h0000_0000);
        apb(0, 12'h010, 0); chk({rd[30:0], er}, 32'h0000_0001);
        sys_power_in <= 1;
        cyc(3); chk({28'h0, grn}, 32'h0000_0008);
        apb(1, `SHL_OFF_CTRL, 1); cyc(3); chk({28'h0, grn}, 32'h0000_000C);
        apb(0, `SHL_OFF_LEDS, 0); chk(rd, 32'h0000_0101);
        apb(1, `SHL_OFF_CTRL, 3); cyc(3); chk({28'h0, grn}, 32'h0000_000E);
        apb(1, `SHL_OFF_CTRL, 7); cyc(3); chk({28'h0, grn}, 32'h0000_000F);
        apb(0, `SHL_OFF_CTRL, 0); chk(rd, 32'h0000_0007);
        unit_u.report(4'h4, 4'h0, 8'h00, 8'h00);
        cyc(3); chk({20'h0, ic, ec}, 32'h0000_0004);
        chk({28'h0, grn}, 32'h0000_000B);
        apb(0, `SHL_OFF_FAULTS, 0); chk(rd, 32'h0000_0004);
        apb(0, `SHL_OFF_LEDS, 0); chk(rd, 32'h0000_0116);
        watch(40); chk({24'h0, hi, lo}, 32'h0000_008F);
        unit_u.report(4'h0, 4'h0, 8'h81, 8'h01);
        cyc(3); chk({20'h0, ic, ec}, 32'h0000_0814);
        chk({28'h0, grn}, 32'h0000_0009);
        watch(40); chk({24'h0, hi, lo}, 32'h0000_00CF);
        unit_u.report(4'h0, 4'h4, 8'h00, 8'h00);
        cyc(3); chk({28'h0, grn}, 32'h0000_000D);
        sys_power_in <= 0;
        cyc(3); chk({28'h0, grn}, 32'h0000_0000);
        apb(0, `SHL_OFF_FAULTS, 0); chk(rd, 32'h0081_0000);
        unit_u.report(4'h0, 4'h0, 8'h00, 8'h01);
        cyc(3); chk({28'h0, grn}, 32'h0000_0000);
        unit_u.report(4'h0, 4'h0, 8'h00, 8'h80);
        cyc(3); chk({28'h0, grn}, 32'h0000_0002);
        sys_power_in <= 1;
        cyc(3); chk({28'h0, grn}, 32'h0000_000C);
        apb(1, `SHL_OFF_EVENT, 1); apb(0, `SHL_OFF_EVENT, 0); chk(rd, 32'h0000_0001);
        watch(40); chk({24'h0, hi, lo}, 32'h0000_002F);
        apb(1, `SHL_OFF_EVENT, 4); apb(0, `SHL_OFF_EVENT, 0); chk(rd, 32'h0000_0000);
        apb(1, `SHL_OFF_EVENT, 2); watch(20); chk({24'h0, hi, lo}, 32'h0000_001F);
        apb(0, `SHL_OFF_LEDS, 0); chk(rd, 32'h0000_0131);
        hard_reset_in <= 1;
        cyc(1);
        hard_reset_in <= 0;
        apb(0, `SHL_OFF_EVENT, 0); chk(rd, 32'h0000_0000);
        unit_u.report(4'h1, 4'h0, 8'h02, 8'h00);
        cyc(3);
        rst_n_in <= 0;
        cyc(2);
        rst_n_in <= 1;
        cyc(2);
        apb(0, `SHL_OFF_FAULTS, 0); chk(rd, 32'h0000_0000);
        chk({28'h0, grn}, 32'h0000_0008);
        end_sim();
    end
    // watchdog against a hung handshake
    initial begin
        cyc(3000);
        n_fail++;
        $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1, 0);
        end_sim();
    end
endmodule
`default_nettype wire
